//--- ppb_top.sv
// Level 3 transmit PHY sink bridged to a streaming slave source, AXI4-Lite control
// Summary of operation
// RULE1: A streaming master sink reads while our data-available is high; no burst limits.
// RULE2: Slave sink flag high below full threshold, hysteresis up to burst threshold.
// RULE3: Slave source flag high above empty threshold, held high down to burst.
// RULE4: Buffer word width equals the wider of link and streaming widths.
// RULE5: Each buffer word carries at most one packet.
// RULE6: Streaming side is always direct, with no channel addressing.
// RULE7: Level 3 multi-channel direct uses one transmit available pin per channel.
// RULE8: Level 3 polled uses address, polled and selected flags; option drops selected.
// RULE9: Single-channel direct uses start-of-transfer; no-addressing variant omits it.
// RULE10: Level 2 direct uses one available pin per channel each direction.
// RULE11: Level 2 polled uses address plus polled and selected flags; option drops selected.
// RULE12: Base address matching only in level 2; range base to base plus count.
// RULE13: Start-of-transfer emitters vary; sinks accept every pattern.
// RULE14: Resets assert asynchronously, release synchronously to their own clock.
// RULE15: Resets are not per channel; all channels reset together.
// RULE16: PHY build takes link-to-PHY signals in, drives PHY-to-link out.
// RULE17: Transmit transfers follow the transmit clock, at most 104 MHz.
// RULE18: Data big-endian on 32 bits, valid with write enable; 8-bit uses low lane.
// RULE19: Link marks first and last transfer with start and end markers.
// RULE20: Error flag comes only with end marker and aborts the packet.
// RULE21: Parity over data checked while enabled; errors reported, data untouched.
// RULE22: Modulo zero except on last word; codes give valid upper bytes.
// RULE23: Data processed with enable low; start-of-transfer address when high.
// RULE24: Even or odd parity chosen at build time for the whole bus.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ppb_regs.svh"
module ppb_top
    import ppb_pkg::*;
#(
    parameter logic PAR_ODD = 1'b0
) (
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [`PPB_AW-1:0] AXI_AWADDR_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    output logic [1:0] AXI_BRESP_OUT,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    input wire logic [`PPB_AW-1:0] AXI_ARADDR_IN,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    input wire logic TFCLK_IN,
    input wire logic TX_ENB_N_IN,
    input wire logic TX_SX_IN,
    input wire logic TX_SOP_IN,
    input wire logic TX_EOP_IN,
    input wire logic TX_ERR_IN,
    input wire logic TX_PRTY_IN,
    input wire logic [1:0] TX_MOD_IN,
    input wire logic [7:0] TX_ADR_IN,
    input wire logic [31:0] TX_DAT_IN,
    output logic TX_DPA_OUT,
    output logic TX_PPA_OUT,
    output logic TX_SPA_OUT,
    input wire logic SRC_ENA_IN,
    output logic SRC_DAV_OUT,
    output logic SRC_VAL_OUT,
    output logic SRC_SOP_OUT,
    output logic SRC_EOP_OUT,
    output logic SRC_ERR_OUT,
    output logic [1:0] SRC_MTY_OUT,
    output logic [31:0] SRC_DAT_OUT
);
    // =====================================================================
    // State
    typedef struct packed {
        ppb_pins_t meta;
        ppb_pins_t sync;
        logic clk_prev;
        logic [`PPB_CTRL_W-1:0] ctrl;
        logic [7:0] base;
        logic [31:0] thr;
        logic [7:0] perr;
        logic [7:0] abort;
        logic [7:0] sel;
        logic [7:0] poll;
        logic [31:0] acc;
        logic [1:0] cnt;
        logic acc_sop;
        logic dpa;
        logic ppa;
        logic spa;
        ppb_word_t out;
        logic val;
        logic awrdy;
        logic wrdy;
        logic aw_ok;
        logic w_ok;
        logic [`PPB_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ppb_top_s_t;
    ppb_top_s_t s_q;
    ppb_top_s_t s_d;
    logic [1:0] rsync_q;
    logic rst_n;
    ppb_pins_t pins;
    ppb_pa_mode_t mode;
    logic level2;
    logic bus8;
    logic fe;
    logic push;
    logic pop;
    logic perr_hit;
    logic sx_hit;
    logic [1:0] c;
    logic [31:0] acc_n;
    ppb_word_t pword;
    ppb_word_t rword;
    logic [`PPB_LVL_W-1:0] level;
    logic eop_any;
    logic tx_pa;

    // =====================================================================
    // Reset release
    // Release is retimed here so the link side need not be in our domain
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rsync_q <= 2'h0;
        end else if (CE_IN) begin
            rsync_q <= {rsync_q[0], 1'b1}; // RULE14
        end
    end
    assign rst_n = rsync_q[1];

    // =====================================================================
    // Helpers
    assign pins = '{tfclk: TFCLK_IN, enb_n: TX_ENB_N_IN, sx: TX_SX_IN, sop: TX_SOP_IN,
                    eop: TX_EOP_IN, err: TX_ERR_IN, prty: TX_PRTY_IN, mod: TX_MOD_IN,
                    adr: TX_ADR_IN, dat: TX_DAT_IN}; // RULE16
    assign mode = ppb_pa_mode_t'(s_q.ctrl[`PPB_CTRL_MODE_MSB:`PPB_CTRL_MODE_LSB]);
    assign level2 = s_q.ctrl[`PPB_CTRL_L2_BIT];
    assign bus8 = s_q.ctrl[`PPB_CTRL_B8_BIT];
    // Sampled mid-period so link data is stable after its rising edge
    assign fe = s_q.clk_prev && !s_q.sync.tfclk; // RULE17

    function automatic logic addr_ok(input logic [7:0] a, input logic l2, input logic [7:0] b);
        logic [7:0] lo;
        lo = l2 ? b : 8'h00; // RULE12
        addr_ok = (a >= lo) && (a < lo + `PPB_NCH);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] st);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                merge[i*8 +: 8] = n[i*8 +: 8];
            end
        end
    endfunction

    // =====================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        push = 1'b0;
        pword = '0;
        perr_hit = 1'b0;
        sx_hit = 1'b0;
        c = s_q.sync.sop ? 2'h0 : s_q.cnt;
        acc_n = s_q.sync.sop ? 32'h0000_0000 : s_q.acc;
        pop = SRC_ENA_IN && (level != '0);
        s_d.meta = pins;
        s_d.sync = s_q.meta;
        s_d.clk_prev = s_q.sync.tfclk;

        // Register write, placed first so hardware events win over clears
        if (AXI_AWVALID_IN && s_q.awrdy) begin
            s_d.aw_ok = 1'b1;
            s_d.awrdy = 1'b0;
            s_d.awaddr = AXI_AWADDR_IN;
        end
        if (AXI_WVALID_IN && s_q.wrdy) begin
            s_d.w_ok = 1'b1;
            s_d.wrdy = 1'b0;
            s_d.wdata = AXI_WDATA_IN;
            s_d.wstrb = AXI_WSTRB_IN;
        end
        if (s_q.aw_ok && s_q.w_ok) begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `PPB_RESP_OKAY;
            case (s_q.awaddr)
                `PPB_OFS_CTRL: begin
                    s_d.ctrl = `PPB_CTRL_W'(merge({28'h0, s_q.ctrl}, s_q.wdata, s_q.wstrb));
                end
                `PPB_OFS_BASE: begin
                    s_d.base = 8'(merge({24'h0, s_q.base}, s_q.wdata, s_q.wstrb));
                end
                `PPB_OFS_THR: begin
                    s_d.thr = merge(s_q.thr, s_q.wdata, s_q.wstrb);
                end
                `PPB_OFS_STAT: begin
                    s_d.perr = 8'h00;
                    s_d.abort = 8'h00;
                end
                default: begin
                    s_d.bresp = `PPB_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && AXI_BREADY_IN) begin
            s_d.bvalid = 1'b0;
            s_d.awrdy = 1'b1;
            s_d.wrdy = 1'b1;
        end

        // Register read
        if (AXI_ARVALID_IN && s_q.arrdy) begin
            s_d.arrdy = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = `PPB_RESP_OKAY;
            case (AXI_ARADDR_IN)
                `PPB_OFS_CTRL: s_d.rdata = {28'h0, s_q.ctrl};
                `PPB_OFS_BASE: s_d.rdata = {24'h0, s_q.base};
                `PPB_OFS_THR: s_d.rdata = s_q.thr;
                `PPB_OFS_STAT: s_d.rdata = {s_q.sel, s_q.abort, s_q.perr, 3'h0, level};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = `PPB_RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && AXI_RREADY_IN) begin
            s_d.rvalid = 1'b0;
            s_d.arrdy = 1'b1;
        end

        // Link sink, one decision per transmit clock period
        if (fe) begin
            s_d.poll = s_q.sync.adr;
            if (!s_q.sync.enb_n) begin
                // Checked only; the word goes on unchanged
                if ((^{s_q.sync.dat, s_q.sync.prty}) != PAR_ODD) begin // RULE24
                    perr_hit = 1'b1; // RULE21
                end
                if (s_q.sync.err && s_q.sync.eop && s_d.abort != 8'hFF) begin
                    s_d.abort = s_d.abort + 8'h01; // RULE20
                end
                if (mode == PPB_PA_NOADDR || addr_ok(s_q.sel, level2, s_q.base)) begin // RULE23
                    if (!bus8) begin
                        push = 1'b1; // RULE18
                        pword.sop = s_q.sync.sop; // RULE19
                        pword.eop = s_q.sync.eop;
                        pword.err = s_q.sync.err && s_q.sync.eop; // RULE20
                        pword.mty = s_q.sync.eop ? s_q.sync.mod : 2'h0; // RULE22
                        pword.dat = s_q.sync.dat;
                    end else begin
                        // Narrow link packs bytes big-endian into one word
                        acc_n[{2'(2'h3 - c), 3'h0} +: 8] = s_q.sync.dat[7:0]; // RULE18
                        if (c == 2'h0) begin
                            s_d.acc_sop = s_q.sync.sop;
                        end
                        if (s_q.sync.eop || c == 2'h3) begin
                            push = 1'b1;
                            pword.sop = (c == 2'h0) ? s_q.sync.sop : s_q.acc_sop;
                            pword.eop = s_q.sync.eop;
                            pword.err = s_q.sync.err && s_q.sync.eop; // RULE20
                            pword.mty = s_q.sync.eop ? 2'(2'h3 - c) : 2'h0; // RULE22
                            pword.dat = acc_n;
                            s_d.cnt = 2'h0;
                        end else begin
                            s_d.cnt = c + 2'h1;
                        end
                        s_d.acc = acc_n;
                    end
                end
            end else if (s_q.sync.sx && mode != PPB_PA_NOADDR) begin
                // Any start-of-transfer pattern is taken as it comes
                sx_hit = 1'b1; // RULE13
                s_d.sel = s_q.sync.dat[7:0]; // RULE9
            end
        end
        if (perr_hit && s_d.perr != 8'hFF) begin
            s_d.perr = s_d.perr + 8'h01; // RULE21
        end

        // Packet-available pins for the single transmit channel
        unique case (mode)
            PPB_PA_DIRECT, PPB_PA_NOADDR: begin
                s_d.dpa = tx_pa; // RULE7 RULE10
                s_d.ppa = 1'b0;
                s_d.spa = 1'b0;
            end
            PPB_PA_POLL: begin
                s_d.dpa = 1'b0;
                s_d.ppa = tx_pa && addr_ok(s_q.poll, level2, s_q.base); // RULE8 RULE11
                s_d.spa = tx_pa && addr_ok(s_q.sel, level2, s_q.base); // RULE8 RULE11
            end
            PPB_PA_POLL_NOSTPA: begin
                s_d.dpa = 1'b0;
                s_d.ppa = tx_pa && addr_ok(s_q.poll, level2, s_q.base); // RULE8 RULE11
                s_d.spa = 1'b0;
            end
        endcase

        // Streaming slave source: direct, no channel address
        s_d.val = pop; // RULE6
        if (pop) begin
            s_d.out = rword; // RULE1
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrl <= `PPB_CTRL_RST;
            s_q.base <= `PPB_BASE_RST;
            s_q.thr <= `PPB_THR_RST;
            s_q.awrdy <= 1'b1;
            s_q.wrdy <= 1'b1;
            s_q.arrdy <= 1'b1;
        end else if (CE_IN) begin
            s_q <= s_d;
        end
    end

    // =====================================================================
    // Buffer and flow flags
    ppb_fifo u_fifo (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .push_in(push),
        .word_in(pword),
        .pop_in(pop),
        .word_out(rword),
        .level_out(level),
        .eop_any_out(eop_any)
    );

    ppb_dav u_tx_pa (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .sink_in(1'b1),
        .level_in(level),
        .hi_in(s_q.thr[`PPB_THR_BURST_LSB +: `PPB_LVL_W]),
        .lo_in(s_q.thr[`PPB_THR_FULL_LSB +: `PPB_LVL_W]),
        .force_in(1'b0),
        .dav_out(tx_pa)
    );

    ppb_dav u_src_dav (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .sink_in(1'b0),
        .level_in(level),
        .hi_in(s_q.thr[`PPB_THR_EMPTY_LSB +: `PPB_LVL_W]),
        .lo_in(s_q.thr[`PPB_THR_SBURST_LSB +: `PPB_LVL_W]),
        .force_in(eop_any),
        .dav_out(SRC_DAV_OUT)
    );

    // =====================================================================
    // Outputs
    assign AXI_AWREADY_OUT = s_q.awrdy;
    assign AXI_WREADY_OUT = s_q.wrdy;
    assign AXI_BVALID_OUT = s_q.bvalid;
    assign AXI_BRESP_OUT = s_q.bresp;
    assign AXI_ARREADY_OUT = s_q.arrdy;
    assign AXI_RVALID_OUT = s_q.rvalid;
    assign AXI_RDATA_OUT = s_q.rdata;
    assign AXI_RRESP_OUT = s_q.rresp;
    assign TX_DPA_OUT = s_q.dpa;
    assign TX_PPA_OUT = s_q.ppa;
    assign TX_SPA_OUT = s_q.spa;
    assign SRC_VAL_OUT = s_q.val;
    assign SRC_SOP_OUT = s_q.out.sop;
    assign SRC_EOP_OUT = s_q.out.eop;
    assign SRC_ERR_OUT = s_q.out.err;
    assign SRC_MTY_OUT = s_q.out.mty;
    assign SRC_DAT_OUT = s_q.out.dat;

    // =====================================================================
    // Checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!rst_n);
    sequence s_data_edge;
        CE_IN && fe && !s_q.sync.enb_n;
    endsequence
    property p_parity;
        s_data_edge ##0 perr_hit |=> s_q.perr != 8'h00;
    endproperty
    a_parity: assert property (p_parity) else $error("parity error not counted"); // RULE21
    property p_read;
        CE_IN && SRC_ENA_IN && level != '0 |=> SRC_VAL_OUT;
    endproperty
    a_read: assert property (p_read) else $error("read enable gave no data"); // RULE1
    property p_mod;
        SRC_VAL_OUT && !SRC_EOP_OUT |-> SRC_MTY_OUT == 2'h0;
    endproperty
    a_mod: assert property (p_mod) else $error("modulo set away from end"); // RULE22
    property p_err;
        SRC_VAL_OUT && SRC_ERR_OUT |-> SRC_EOP_OUT;
    endproperty
    a_err: assert property (p_err) else $error("error without end marker"); // RULE20
    property p_nostpa;
        CE_IN && mode == PPB_PA_POLL_NOSTPA |=> !TX_SPA_OUT;
    endproperty
    a_nostpa: assert property (p_nostpa) else $error("selected flag in ignore mode"); // RULE8
    property p_direct;
        CE_IN && mode == PPB_PA_DIRECT |=> !TX_PPA_OUT && TX_DPA_OUT == $past(tx_pa);
    endproperty
    a_direct: assert property (p_direct) else $error("direct pin wrong"); // RULE7
    property p_sx;
        CE_IN && sx_hit |=> s_q.sel == $past(s_q.sync.dat[7:0]);
    endproperty
    a_sx: assert property (p_sx) else $error("address cycle not taken"); // RULE23
endmodule
`default_nettype wire

//--- ppb_regs.svh
// Register offsets, field positions, reset values and sizes of the packet bridge
`ifndef PPB_REGS_SVH
`define PPB_REGS_SVH
`define PPB_AW 6
`define PPB_OFS_CTRL 6'h00
`define PPB_OFS_BASE 6'h04
`define PPB_OFS_THR 6'h08
`define PPB_OFS_STAT 6'h0C
`define PPB_CTRL_W 4
`define PPB_CTRL_MODE_LSB 0
`define PPB_CTRL_MODE_MSB 1
`define PPB_CTRL_L2_BIT 2
`define PPB_CTRL_B8_BIT 3
`define PPB_CTRL_RST 4'h0
`define PPB_BASE_RST 8'h00
`define PPB_THR_RST 32'h0002_0C08
`define PPB_THR_FULL_LSB 0
`define PPB_THR_BURST_LSB 8
`define PPB_THR_EMPTY_LSB 16
`define PPB_THR_SBURST_LSB 24
`define PPB_DEPTH 16
`define PPB_PTR_W 4
`define PPB_LVL_W 5
`define PPB_NCH 8'h01
`define PPB_RESP_OKAY 2'h0
`define PPB_RESP_SLVERR 2'h2
`endif

//--- ppb_pkg.sv
// Types shared by the packet bridge modules
package ppb_pkg;
    // Word width is the wider of link and streaming widths
    localparam int PPB_LINK_W = 32;
    localparam int PPB_STRM_W = 32;
    localparam int PPB_FIFO_W = (PPB_LINK_W > PPB_STRM_W) ? PPB_LINK_W : PPB_STRM_W; // RULE4
    typedef enum logic [1:0] {
        PPB_PA_DIRECT = 2'h0,
        PPB_PA_POLL = 2'h1,
        PPB_PA_POLL_NOSTPA = 2'h3,
        PPB_PA_NOADDR = 2'h2
    } ppb_pa_mode_t;
    typedef struct packed {
        logic sop;
        logic eop;
        logic err;
        logic [1:0] mty;
        logic [PPB_FIFO_W-1:0] dat;
    } ppb_word_t;
    typedef struct packed {
        logic tfclk;
        logic enb_n;
        logic sx;
        logic sop;
        logic eop;
        logic err;
        logic prty;
        logic [1:0] mod;
        logic [7:0] adr;
        logic [PPB_LINK_W-1:0] dat;
    } ppb_pins_t;
endpackage

//--- ppb_fifo.sv
// Flip-flop packet word buffer, one packet at most per word
`timescale 1ns/100ps
`default_nettype none
`include "ppb_regs.svh"
module ppb_fifo
    import ppb_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic push_in,
    input wire ppb_word_t word_in,
    input wire logic pop_in,
    output ppb_word_t word_out,
    output logic [`PPB_LVL_W-1:0] level_out,
    output logic eop_any_out
);
    typedef struct packed {
        ppb_word_t [`PPB_DEPTH-1:0] mem;
        logic [`PPB_PTR_W-1:0] wp;
        logic [`PPB_PTR_W-1:0] rp;
        logic [`PPB_LVL_W-1:0] lvl;
        logic [`PPB_LVL_W-1:0] neop;
    } ppb_fifo_s_t;
    ppb_fifo_s_t s_q;
    ppb_fifo_s_t s_d;
    logic wr;
    logic rd;

    always_comb begin
        s_d = s_q;
        wr = push_in && (s_q.lvl != 5'(`PPB_DEPTH));
        rd = pop_in && (s_q.lvl != '0);
        // Each pushed word is a whole entry, short packets waste the rest
        if (wr) begin
            s_d.mem[s_q.wp] = word_in; // RULE5
            s_d.wp = s_q.wp + 4'h1;
        end
        if (rd) begin
            s_d.rp = s_q.rp + 4'h1;
        end
        s_d.lvl = s_q.lvl + 5'(wr) - 5'(rd);
        s_d.neop = s_q.neop + 5'(wr && word_in.eop) - 5'(rd && s_q.mem[s_q.rp].eop);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign word_out = s_q.mem[s_q.rp];
    assign level_out = s_q.lvl;
    assign eop_any_out = (s_q.neop != '0);

    property p_one_word;
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && wr && !rd |=> s_q.lvl == $past(s_q.lvl) + 5'h01;
    endproperty
    a_one_word: assert property (p_one_word) else $error("push did not take one word"); // RULE5
endmodule
`default_nettype wire

//--- ppb_dav.sv
// Data-available flag with fill-level hysteresis for sink or source role
`timescale 1ns/100ps
`default_nettype none
`include "ppb_regs.svh"
module ppb_dav (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic sink_in,
    input wire logic [`PPB_LVL_W-1:0] level_in,
    input wire logic [`PPB_LVL_W-1:0] hi_in,
    input wire logic [`PPB_LVL_W-1:0] lo_in,
    input wire logic force_in,
    output logic dav_out
);
    typedef struct packed {
        logic dav;
    } ppb_dav_s_t;
    ppb_dav_s_t s_q;
    ppb_dav_s_t s_d;

    always_comb begin
        s_d = s_q;
        if (sink_in) begin
            if (s_q.dav && level_in >= hi_in) begin
                s_d.dav = 1'b0; // RULE2
            end else if (!s_q.dav && level_in < lo_in) begin
                s_d.dav = 1'b1; // RULE2
            end
        end else begin
            // A stored packet end counts as data even below threshold
            if (level_in > hi_in || force_in) begin
                s_d.dav = 1'b1; // RULE3
            end else if (level_in <= lo_in) begin
                s_d.dav = 1'b0; // RULE3
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign dav_out = s_q.dav;

    property p_sink_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && sink_in && s_q.dav && level_in >= hi_in |=> !dav_out;
    endproperty
    a_sink_off: assert property (p_sink_off) else $error("sink flag kept past burst"); // RULE2
    property p_src_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && !sink_in && s_q.dav && level_in > lo_in |=> dav_out;
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source flag dropped early"); // RULE3
endmodule
`default_nettype wire

//--- ppb_link_model.sv
// Link transmit model driving the bridge's sink pins
`timescale 1ns/100ps
`default_nettype none
module ppb_link_model #(
    parameter logic PAR_ODD = 1'b0
) (
    output logic tfclk_out,
    output logic enb_n_out,
    output logic sx_out,
    output logic [4:0] ctl_out,
    output logic prty_out,
    output logic [7:0] adr_out,
    output logic [31:0] dat_out
);
    initial begin
        {tfclk_out, sx_out, ctl_out, prty_out, adr_out} = '0;
        enb_n_out = 1'b1;
        dat_out = 32'hA55A_5AA5;
    end
    // Clock stands low between words; bad breaks parity on purpose
    task automatic send(input logic [4:0] c, input logic [31:0] d, input logic bad);
        #7 ctl_out = c;
        dat_out = d;
        prty_out = ^d ^ PAR_ODD ^ bad;
        enb_n_out = 1'b0;
        #80 tfclk_out = 1'b1;
        #80 tfclk_out = 1'b0;
        #80 enb_n_out = 1'b1;
        ctl_out = '0;
        dat_out = ~d;
    endtask
endmodule
`default_nettype wire

//--- ppb_top_tb_top.sv
// Bench: link model feeds the bridge, bus and stream results checked from queues
`timescale 1ns/100ps
`default_nettype none
module ppb_top_tb_top;
    logic CLK_SYS_IN = 1'b0, RSTN_IN = 1'b0, CE_IN = 1'b1, SRC_ENA_IN = 1'b0;
    logic AXI_AWVALID_IN = 1'b0, AXI_WVALID_IN = 1'b0, AXI_BREADY_IN = 1'b0;
    logic AXI_ARVALID_IN = 1'b0, AXI_RREADY_IN = 1'b0;
    logic [5:0] AXI_AWADDR_IN = '0, AXI_ARADDR_IN = '0;
    logic [31:0] AXI_WDATA_IN = '0, AXI_RDATA_OUT, TX_DAT_IN, SRC_DAT_OUT, r;
    logic [3:0] AXI_WSTRB_IN = 4'hF;
    logic AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT, AXI_RVALID_OUT;
    logic [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT, TX_MOD_IN, SRC_MTY_OUT;
    logic [7:0] TX_ADR_IN;
    logic TFCLK_IN, TX_ENB_N_IN, TX_SX_IN, TX_SOP_IN, TX_EOP_IN, TX_ERR_IN, TX_PRTY_IN;
    logic TX_DPA_OUT, TX_PPA_OUT, TX_SPA_OUT, SRC_DAV_OUT, SRC_VAL_OUT;
    logic SRC_SOP_OUT, SRC_EOP_OUT, SRC_ERR_OUT;
    int n_mismatch = 0, comparisons = 0, seed = 50, cyc = 0, i;
    logic [33:0] aq[$];
    logic [36:0] sq[$];
    ppb_top ppb_top_i (.*);
    ppb_link_model ppb_link_model_i (.tfclk_out(TFCLK_IN), .enb_n_out(TX_ENB_N_IN),
        .sx_out(TX_SX_IN), .ctl_out({TX_SOP_IN, TX_EOP_IN, TX_ERR_IN, TX_MOD_IN}),
        .prty_out(TX_PRTY_IN), .adr_out(TX_ADR_IN), .dat_out(TX_DAT_IN));
    initial begin
        forever #10 CLK_SYS_IN = ~CLK_SYS_IN;
    end
    function automatic void chk(string nm, logic [36:0] e, logic [36:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endfunction
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========
    // Watcher: oldest note against each result, plus hang limit
    always @(posedge CLK_SYS_IN) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
        if (AXI_BVALID_OUT && AXI_BREADY_IN) chk("bresp", aq.pop_front(), {AXI_BRESP_OUT, 32'h0});
        if (AXI_RVALID_OUT && AXI_RREADY_IN) chk("rd", aq.pop_front(), {AXI_RRESP_OUT, AXI_RDATA_OUT});
        if (SRC_VAL_OUT !== 1'b0) chk("word", sq.pop_front(), {SRC_SOP_OUT, SRC_EOP_OUT,
            SRC_ERR_OUT, SRC_MTY_OUT, SRC_DAT_OUT});
    end
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic aw = 1'b0, w = 1'b0;
        aq.push_back(34'h0);
        @(posedge CLK_SYS_IN);
        AXI_AWADDR_IN <= a;
        AXI_WDATA_IN <= d;
        {AXI_AWVALID_IN, AXI_WVALID_IN, AXI_BREADY_IN} <= 3'h7;
        while (!(aw && w)) begin
            @(posedge CLK_SYS_IN);
            aw |= AXI_AWREADY_OUT;
            w |= AXI_WREADY_OUT;
            if (aw) AXI_AWVALID_IN <= 1'b0;
            if (w) AXI_WVALID_IN <= 1'b0;
        end
        do @(posedge CLK_SYS_IN); while (AXI_BVALID_OUT !== 1'b1);
        AXI_BREADY_IN <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [33:0] e);
        aq.push_back(e);
        @(posedge CLK_SYS_IN);
        AXI_ARADDR_IN <= a;
        {AXI_ARVALID_IN, AXI_RREADY_IN} <= 2'h3;
        do @(posedge CLK_SYS_IN); while (AXI_ARREADY_OUT !== 1'b1);
        AXI_ARVALID_IN <= 1'b0;
        do @(posedge CLK_SYS_IN); while (AXI_RVALID_OUT !== 1'b1);
        AXI_RREADY_IN <= 1'b0;
    endtask
    task automatic pull(input int n);
        @(posedge CLK_SYS_IN);
        SRC_ENA_IN <= 1'b1;
        repeat (n) @(posedge CLK_SYS_IN);
        SRC_ENA_IN <= 1'b0;
        repeat (4) @(posedge CLK_SYS_IN);
    endtask
    task automatic tx(input logic [4:0] c, input logic bad);
        r = $random(seed);
        sq.push_back({c, r});
        ppb_link_model_i.send(c, r, bad);
        repeat (6) @(posedge CLK_SYS_IN);
    endtask
    initial begin
        repeat (3) @(posedge CLK_SYS_IN);
        RSTN_IN <= 1'b1;
        repeat (6) @(posedge CLK_SYS_IN);
        chk("dpa", 1'b1, TX_DPA_OUT);
        chk("dav", 1'b0, SRC_DAV_OUT);
        rd(6'h08, 34'h0_0002_0C08);
        rd(6'h10, 34'h2_0000_0000);
        r = $random(seed);
        wr(6'h04, r);
        rd(6'h04, {26'h0, r[7:0]});
        tx(5'h10, 1'b0);
        tx(5'h0A, 1'b0);
        chk("dav", 1'b1, SRC_DAV_OUT);
        pull(4);
        chk("dav", 1'b0, SRC_DAV_OUT);
        tx(5'h1F, 1'b1);
        pull(2);
        rd(6'h0C, 34'h0_0001_0100);
        wr(6'h0C, 32'h0);
        rd(6'h0C, 34'h0);
        for (i = 0; i < 10; i++) tx(5'h18, 1'b0);
        chk("dpa", 1'b1, TX_DPA_OUT);
        tx(5'h18, 1'b0);
        tx(5'h18, 1'b0);
        chk("dpa", 1'b0, TX_DPA_OUT);
        pull(3);
        chk("dpa", 1'b0, TX_DPA_OUT);
        pull(9);
        chk("dpa", 1'b1, TX_DPA_OUT);
        wr(6'h00, 32'h3);
        rd(6'h00, 34'h3);
        chk("pa", 3'h4, {TX_PPA_OUT, TX_SPA_OUT, TX_DPA_OUT});
        complete_run();
    end
endmodule
`default_nettype wire
